/* File: rtl/sbsp_defs.vh */
`ifndef SBSP_DEFS_VH
`define SBSP_DEFS_VH

// Word geometry: four byte lanes, eight data bits plus one parity bit each
`define SBSP_LANES 4
`define SBSP_LANE_W 9
`define SBSP_ADDR_W 19

// Burst counter width and the low address field it drives
`define SBSP_CNT_W 2
`define SBSP_CNT_LSB 0
`define SBSP_CNT_MSB 1

// Reset values
`define SBSP_RST_CNT 2'h0
`define SBSP_RST_MODE 1'h1

// Strap capture: cycles after reset release before the burst order is taken
`define SBSP_STRAP_DELAY 1

`endif

/* File: rtl/sbsp_array.v */
`timescale 1ns/1ps
`include "sbsp_defs.vh"

module sbsp_array #(
	parameter ADDR_W = `SBSP_ADDR_W,
	parameter LANES = `SBSP_LANES,
	parameter LANE_W = `SBSP_LANE_W
) (
	input wire clk,
	input wire wr_en,
	input wire [LANES-1:0] wr_lanes,
	input wire [ADDR_W-1:0] wr_addr,
	input wire [LANES*LANE_W-1:0] wr_data,
	input wire [ADDR_W-1:0] rd_addr,
	output wire [LANES*LANE_W-1:0] rd_data
);
	reg [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
	reg [LANES*LANE_W-1:0] old_word;
	reg [LANES*LANE_W-1:0] next_word;
	integer i;

	assign rd_data = mem[rd_addr];

	// Read-modify-write per lane so untouched lanes keep their bytes
	always @* begin
		old_word = mem[wr_addr];
		next_word = old_word;
		for (i = 0; i < LANES; i = i + 1) begin
			if (wr_lanes[i]) begin
				next_word[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
			end
		end
	end

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= next_word;
		end
	end
endmodule

/* File: rtl/sbsp_port.v */
// Behaviour
// - Address latched on strobe with chip selected
// - Low two address bits seed burst counter
// - Lane select writes only with byte enable
// - Global write writes all lanes
// - Step input advances burst counter
// - Processor strobe ignored when first select high
// - Selected only when selects are low-high-low
// - Output enable low drives data pins in READ state only
// - First read clock from deselect stays undriven
// - Processor strobe loads address and counter
// - Processor strobe wins over controller strobe
// - Controller strobe loads address and counter
// - Static strap picks linear or interleaved order
// - Write data registered; read from prior address
`timescale 1ns/1ps
`include "sbsp_defs.vh"

module sbsp_port #(
	parameter ADDR_W = `SBSP_ADDR_W,
	parameter LANES = `SBSP_LANES,
	parameter LANE_W = `SBSP_LANE_W
) (
	input wire clk,
	input wire nrst,
	input wire [ADDR_W-1:0] addr,
	input wire processor_address_strobe_n,
	input wire controller_address_strobe_n,
	input wire burst_step_n,
	input wire chip_select_first_n,
	input wire chip_select_second,
	input wire chip_select_third_n,
	input wire lane0_write_select_n,
	input wire lane1_write_select_n,
	input wire lane2_write_select_n,
	input wire lane3_write_select_n,
	input wire byte_write_enable_n,
	input wire global_write_n,
	input wire output_enable_n,
	input wire burst_order_strap,
	input wire [LANES*LANE_W-1:0] data_io_lane_in,
	output reg [LANES*LANE_W-1:0] data_io_lane_out,
	output wire [LANES*LANE_W-1:0] data_io_lane_oe
);
	reg [ADDR_W-1:0] addr_reg;
	reg [`SBSP_CNT_W-1:0] cnt_base;
	reg [`SBSP_CNT_W-1:0] cnt_step;
	reg [3:0] state;
	reg interleaved;
	reg strap_taken;

	reg [ADDR_W-1:0] next_addr_reg;
	reg [`SBSP_CNT_W-1:0] next_cnt_base;
	reg [`SBSP_CNT_W-1:0] next_cnt_step;
	reg [3:0] next_state;
	reg write_window;
	reg wr_en;
	reg [LANES-1:0] wr_lanes;
	reg [ADDR_W-1:0] wr_addr;
	reg [ADDR_W-1:0] rd_addr;

	wire [LANES*LANE_W-1:0] rd_data;
	wire [LANES*LANE_W-1:0] next_out;
	wire [LANES-1:0] lane_sel_n;
	wire [ADDR_W-1:0] cur_addr;
	wire [ADDR_W-1:0] step_addr;
	wire [`SBSP_CNT_W-1:0] step_low;
	wire selected;
	wire pss_act;
	wire css_act;
	wire start;
	wire active;
	wire read_ready;
	wire same_word;
	genvar g;

	// One-hot burst states: OPEN is the masked first read clock after a deselect,
	// WRITE keeps the pins quiet while write data is on them
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_OPEN = 4'h2;
	localparam [3:0] ST_READ = 4'h4;
	localparam [3:0] ST_WRITE = 4'h8;

	assign lane_sel_n = {lane3_write_select_n, lane2_write_select_n,
		lane1_write_select_n, lane0_write_select_n};

	// Burst order: linear adds the step, interleaved xors it, both wrap in four
	function [`SBSP_CNT_W-1:0] burst_low;
		input [`SBSP_CNT_W-1:0] base;
		input [`SBSP_CNT_W-1:0] step;
		input ilv;
		begin
			if (ilv) begin
				burst_low = base ^ step;
			end else begin
				burst_low = base + step;
			end
		end
	endfunction

	function [ADDR_W-1:0] with_low;
		input [ADDR_W-1:0] full;
		input [`SBSP_CNT_W-1:0] low;
		begin
			with_low = {full[ADDR_W-1:`SBSP_CNT_W], low};
		end
	endfunction

	assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	assign pss_act = !processor_address_strobe_n && !chip_select_first_n;
	assign css_act = !controller_address_strobe_n && !pss_act;
	assign start = pss_act || css_act;

	assign active = !state[0];
	assign read_ready = state[2];
	assign step_low = cnt_step + 1'b1;

	// Address of the current beat, and of the next one should the step input be low
	assign cur_addr = with_low(addr_reg, burst_low(cnt_base, cnt_step, interleaved));
	assign step_addr = with_low(addr_reg, burst_low(cnt_base, step_low, interleaved));

	// Address register and burst counter
	always @* begin
		next_addr_reg = addr_reg;
		next_cnt_base = cnt_base;
		next_cnt_step = cnt_step;
		wr_addr = cur_addr;
		rd_addr = cur_addr;
		if (start) begin
			if (selected) begin
				next_addr_reg = addr;
				next_cnt_base = addr[`SBSP_CNT_MSB:`SBSP_CNT_LSB];
				next_cnt_step = `SBSP_RST_CNT;
				wr_addr = addr;
				rd_addr = addr;
			end
		end else if (active && !burst_step_n) begin
			// Write lands on the current beat, the read looks ahead to the next
			next_cnt_step = step_low;
			rd_addr = step_addr;
		end
	end

	// A processor strobe with the chip selected opens a read; writes come on later cycles
	always @* begin
		write_window = active;
		if (start) begin
			write_window = selected && !pss_act;
		end
	end

	// Global write overrides the lane selects, which need the byte enable
	always @* begin
		wr_lanes = {LANES{1'b0}};
		if (write_window) begin
			if (!global_write_n) begin
				wr_lanes = {LANES{1'b1}};
			end else if (!byte_write_enable_n) begin
				wr_lanes = ~lane_sel_n;
			end
		end
		wr_en = |wr_lanes;
	end

	// Pins may drive only in READ
	always @* begin
		next_state = ST_IDLE;
		case (state)
			ST_IDLE: begin
				if (start && selected) begin
					next_state = ST_OPEN;
				end
			end
			ST_OPEN, ST_READ, ST_WRITE: begin
				if (start && !selected) begin
					next_state = ST_IDLE;
				end else if (wr_en) begin
					next_state = ST_WRITE;
				end else begin
					next_state = ST_READ;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Registered read with write pass-through onto the same word
	assign same_word = wr_en && (wr_addr == rd_addr);

	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			assign next_out[g*LANE_W +: LANE_W] = (same_word && wr_lanes[g]) ?
				data_io_lane_in[g*LANE_W +: LANE_W] : rd_data[g*LANE_W +: LANE_W];
		end
	endgenerate

	sbsp_array #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LANE_W)
	) u_array (
		.clk(clk),
		.wr_en(wr_en),
		.wr_lanes(wr_lanes),
		.wr_addr(wr_addr),
		.wr_data(data_io_lane_in),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// Strap taken once after reset release; later changes are ignored by design
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			interleaved <= `SBSP_RST_MODE;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			interleaved <= burst_order_strap;
			strap_taken <= 1'b1;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= {ADDR_W{1'b0}};
			cnt_base <= `SBSP_RST_CNT;
			cnt_step <= `SBSP_RST_CNT;
		end else begin
			addr_reg <= next_addr_reg;
			cnt_base <= next_cnt_base;
			cnt_step <= next_cnt_step;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Read data stands a full clock; only the pin enable follows its pin at once
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_io_lane_out <= {(LANES*LANE_W){1'b0}};
		end else begin
			data_io_lane_out <= next_out;
		end
	end

	// Output enable is asynchronous, so this gate cannot sit behind a flop
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_pin
			assign data_io_lane_oe[g*LANE_W +: LANE_W] =
				{LANE_W{read_ready && !output_enable_n}};
		end
	endgenerate
endmodule

/* File: verif/sbsp_props.sv */
`timescale 1ns/1ps
module sbsp_props #(parameter LANES = 4, LANE_W = 9) (
	input clk,
	input nrst,
	input processor_address_strobe_n,
	input controller_address_strobe_n,
	input burst_step_n,
	input chip_select_first_n,
	input chip_select_second,
	input chip_select_third_n,
	input byte_write_enable_n,
	input global_write_n,
	input output_enable_n,
	input [LANES*LANE_W-1:0] data_io_lane_in,
	input [LANES*LANE_W-1:0] data_io_lane_out,
	input [LANES*LANE_W-1:0] data_io_lane_oe
);
	wire p = !processor_address_strobe_n && !chip_select_first_n;
	wire st = p || !controller_address_strobe_n;
	wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	wire cw = !controller_address_strobe_n && !p && sel && !global_write_n;
	wire hold = !st && burst_step_n && global_write_n && byte_write_enable_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_gate; |data_io_lane_oe |-> !output_enable_n; endproperty
	a_gate: assert property (p_gate) else $error("pins on, oe high");
	property p_even; data_io_lane_oe == 0 || &data_io_lane_oe; endproperty
	a_even: assert property (p_even) else $error("lanes split");
	property p_desel; st && !sel |=> data_io_lane_oe == 0; endproperty
	a_desel: assert property (p_desel) else $error("deselect drives");
	property p_first; st && !sel ##1 p && sel |=> data_io_lane_oe == 0; endproperty
	a_first: assert property (p_first) else $error("first read drives");
	property p_drive;
		p && sel ##1 (!st && !burst_step_n && global_write_n && byte_write_enable_n)
			|=> &data_io_lane_oe || output_enable_n;
	endproperty
	a_drive: assert property (p_drive) else $error("burst not driven");
	property p_pass; cw |=> data_io_lane_out == $past(data_io_lane_in); endproperty
	a_pass: assert property (p_pass) else $error("no pass-through");
	property p_wroe; cw |=> data_io_lane_oe == 0; endproperty
	a_wroe: assert property (p_wroe) else $error("write drives");
	property p_hold; hold && burst_step_n |=> $stable(data_io_lane_out); endproperty
	a_hold: assert property (p_hold) else $error("idle out moved");
endmodule
bind sbsp_port sbsp_props #(.LANES(LANES), .LANE_W(LANE_W)) i_props(.*);

/* File: verif/sbsp_host.sv */
`timescale 1ns/1ps
module sbsp_host #(parameter W = 36) (
	input drive,
	input [W-1:0] wd,
	input [W-1:0] oe,
	input [W-1:0] q,
	output [W-1:0] bus
);
	// Released wire shows inverted read data, so stale data never matches
	assign bus = oe & q | ~oe & (drive ? wd : ~q);
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
	reg clk = 0, nrst = 0, strap = 0, drive = 0, oe_n = 1;
	reg [2:0] cs = 0;
	reg [4:0] c = 5'h1f;
	reg [3:0] bw = 4'hf, b;
	reg [18:0] a = 0;
	reg [35:0] wd = 0, mem [0:15];
	wire [35:0] q, oe, bus;
	integer error_cnt = 0, check_count = 0, i, j, k, m;
	always #20 clk = ~clk;
	sbsp_port i_dut(.clk(clk), .nrst(nrst), .addr(a), .processor_address_strobe_n(c[4]),
		.controller_address_strobe_n(c[3]), .burst_step_n(c[2]), .global_write_n(c[1]),
		.byte_write_enable_n(c[0]), .chip_select_first_n(cs[2]), .chip_select_second(cs[1]),
		.chip_select_third_n(cs[0]), .lane0_write_select_n(bw[0]), .lane1_write_select_n(bw[1]),
		.lane2_write_select_n(bw[2]), .lane3_write_select_n(bw[3]), .output_enable_n(oe_n),
		.burst_order_strap(strap), .data_io_lane_in(bus), .data_io_lane_out(q),
		.data_io_lane_oe(oe));
	sbsp_host i_host(.drive(drive), .wd(wd), .oe(oe), .q(q), .bus(bus));
	task chk(input [15:0] n, input [35:0] s, x); begin
		check_count++;
		if (s !== x) begin
			error_cnt++;
			$display("wrong value %s exp %h seen %h", n, x, s);
		end
	end endtask
	// Controls: selects, host drive, oe, strobes, step, global and byte enables
	task cyc(input [9:0] v, input [3:0] ad, input [3:0] w); begin
		@(negedge clk);
		{cs, drive, oe_n, c} = v;
		a = {15'h0, ad};
		bw = w;
		wd = 36'({$urandom, $urandom});
		@(posedge clk);
		#1;
	end endtask
	function [3:0] lo(input [3:0] s, input [1:0] n);
		lo = {s[3:2], strap ? s[1:0] ^ n : s[1:0] + n};
	endfunction
	task summarize; begin
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	end endtask
	initial begin
		k = $urandom(71);
		for (m = 0; m < 2; m++) begin
			@(negedge clk);
			nrst = 0;
			strap = m[0];
			{cs, drive, oe_n, c} = 10'h017;
			repeat (6) @(negedge clk);
			nrst = 1;
			for (i = 0; i < 16; i++) begin
				cyc(10'h175, i[3:0], 4'hf);
				mem[i] = wd;
				chk("q", q, wd);
			end
			// Odd words keep byte enable high, so their lane selects must not write
			for (i = 0; i < 16; i++) begin
				k = $urandom;
				cyc(10'h176 ^ {9'h0, i[0]}, i[3:0], k[3:0]);
				for (j = 0; j < 4; j++) if (!i[0] && !bw[j]) mem[i][9*j+:9] = wd[9*j+:9];
				cyc(10'h13f, 0, 4'hf);
				chk("q", q, mem[i]);
			end
			cyc(10'h017, 0, 4'hf);
			chk("oe", oe, 0);
			b = 4'($urandom);
			cyc(10'h10f, b, 4'hf);
			chk("q", q, mem[b]);
			chk("oe", oe, 0);
			for (i = 1; i < 4; i++) begin
				cyc(10'h11b, 0, 4'hf);
				chk("q", q, mem[lo(b, i[1:0])]);
				chk("oe", oe, '1);
			end
			cyc(10'h17d, 0, 4'hf);
			mem[lo(b, 2'h3)] = wd;
			chk("q", q, wd);
			cyc(10'h105, b ^ 4'h5, 4'hf);
			chk("q", q, mem[b ^ 4'h5]);
			cyc(10'h30f, 0, 4'hf);
			chk("q", q, mem[b ^ 4'h5]);
			chk("oe", oe, '1);
		end
		summarize;
	end
endmodule
